// ---- include/pcrs_consts.svh ----
/*
  Timing, encoding and reset constants for the primary clock return switch.
  Assumes a 100 MHz mclk and the primary configuration encoding given below.
*/
`ifndef PCRS_CONSTS_SVH
`define PCRS_CONSTS_SVH

// -------------------------------------------------------------------
// clock and timing
// -------------------------------------------------------------------
`define PCRS_MCLK_NS       10
`define PCRS_OST_CYCLES    11'h400
`define PCRS_SYNC_EDGES    4'h8
`define PCRS_CPU_DLY_NS    5000
`define PCRS_CPU_CYCLES    ((`PCRS_CPU_DLY_NS + `PCRS_MCLK_NS - 1) / `PCRS_MCLK_NS)
`define PCRS_INTERNAL_FREQ_STABLE_FLAG_MS       4
`define PCRS_INTERNAL_FREQ_STABLE_FLAG_CYCLES   ((`PCRS_INTERNAL_FREQ_STABLE_FLAG_MS * 1000000) / `PCRS_MCLK_NS)

// -------------------------------------------------------------------
// clock select encodings and reset values
// -------------------------------------------------------------------
`define PCRS_SEL_PRIMARY   2'h0
`define PCRS_SEL_TIMER     2'h1
`define PCRS_SEL_RESET     2'h0
`define PCRS_IFS_SLOWEST   3'h0

// -------------------------------------------------------------------
// primary oscillator configuration codes
// -------------------------------------------------------------------
`define PCRS_PCFG_LP       3'h0
`define PCRS_PCFG_XT       3'h1
`define PCRS_PCFG_HS       3'h2
`define PCRS_PCFG_EXT      3'h3
`define PCRS_PCFG_RC       3'h4
`define PCRS_PCFG_RC_IO    3'h5
`define PCRS_PCFG_INT      3'h6
`define PCRS_PCFG_INT_IO   3'h7

`endif

// ---- include/pcrs_pkg.sv ----
/*
  Types for the primary clock return switch.
  Assumes pcrs_consts.svh is available on the include path.
*/
package pcrs_pkg;

  // system clock source currently steering the core
  typedef enum logic [1:0] {
    SRC_PRIMARY,
    SRC_SLOW_INT,
    SRC_TIMER_XTAL
  } pcrs_src_t;

endpackage : pcrs_pkg

// ---- hdl/pcrs_switch.sv ----
/*
  Primary clock return switch: selects the system clock source, runs the
  crystal start-up timer, the eight-edge sync hold and the status flags.
  Assumes oscillator outputs arrive as asynchronous levels, software bits are
  plain ports, and the core honours core_hold by staying in its first phase.
*/
`include "pcrs_consts.svh"

module pcrs_switch #(
  parameter int unsigned INTERNAL_FREQ_STABLE_FLAG_WAIT = `PCRS_INTERNAL_FREQ_STABLE_FLAG_CYCLES
) (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              primary_osc_clk,
  input  wire logic              slow_internal_osc_clk,
  input  wire logic              timer_crystal_osc_clk,
  input  wire logic [1:0]        clock_select_bits_in,
  input  wire logic              timer_osc_enable,
  input  wire logic [2:0]        primary_osc_config,
  input  wire logic [2:0]        internal_freq_select,
  input  wire logic              dual_speed_enable,
  input  wire logic              woke_from_sleep,
  input  wire logic              watchdog_uses_slow,
  input  wire logic              monitor_uses_slow,
  output logic [1:0]             clock_select_bits,
  output pcrs_pkg::pcrs_src_t    sys_clk_src,
  output logic                   core_hold,
  output logic                   primary_stable_flag,
  output logic                   secondary_clock_active_flag,
  output logic                   internal_freq_stable_flag,
  output logic                   primary_osc_run,
  output logic                   slow_internal_osc_run,
  output logic                   timer_crystal_osc_run
);
  import pcrs_pkg::*;

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_EXTRA,
    ST_RUN,
    ST_OST,
    ST_SYNC
  } pcrs_state_t;

  localparam int unsigned SY_W = 5;

  logic [SY_W-1:0] raw_in;
  logic [SY_W-1:0] sy1_ff;
  logic [SY_W-1:0] sy2_ff;
  logic [SY_W-1:0] sy3_ff;
  logic [SY_W-1:0] filt_ff;
  logic [SY_W-1:0] nxt_filt;
  logic [2:0]      fall;
  pcrs_state_t     state_ff;
  pcrs_src_t       cur_src_ff;
  pcrs_src_t       tgt_src_ff;
  pcrs_src_t       want_src;
  logic [1:0]      sel_ff;
  logic [10:0]     ost_cnt_ff;
  logic [9:0]      cpu_cnt_ff;
  logic [3:0]      edge_cnt_ff;
  logic [18:0]     internal_freq_stable_flag_cnt_ff;
  logic [2:0]      ifs_seen_ff;
  logic            asleep_ff;
  logic            ps_ff;
  logic            sa_ff;
  logic            internal_freq_stable_flag_ff;
  logic            xtal;
  logic            ten_s;
  logic            ten_fall;
  logic            ost_done;
  logic            cpu_done;
  logic            sync_done;
  logic            switch_done;
  logic            ten_prev_ff;

  // -------------------------------------------------------------------
  // input synchronisers
  // -------------------------------------------------------------------
  assign raw_in = {timer_osc_enable, clock_select_bits_in[1], timer_crystal_osc_clk,
                   slow_internal_osc_clk, primary_osc_clk};

  genvar gi;
  generate
    for (gi = 0; gi < SY_W; gi++) begin : g_sync
      // a level counts only once the second and third stages agree
      assign nxt_filt[gi] = (sy2_ff[gi] == sy3_ff[gi]) ? sy3_ff[gi] : filt_ff[gi];
      always_ff @(posedge mclk) begin
        if (reset) begin
          sy1_ff[gi]  <= 1'b0;
          sy2_ff[gi]  <= 1'b0;
          sy3_ff[gi]  <= 1'b0;
          filt_ff[gi] <= 1'b0;
        end else begin
          sy1_ff[gi]  <= raw_in[gi];
          sy2_ff[gi]  <= sy1_ff[gi];
          sy3_ff[gi]  <= sy2_ff[gi];
          filt_ff[gi] <= nxt_filt[gi];
        end
      end
      if (gi < 3) begin : g_fall
        assign fall[gi] = filt_ff[gi] & ~nxt_filt[gi];
      end
    end
  endgenerate

  // bit 0 of the select pair rides a separate synchroniser pass
  logic sel0_s1_ff, sel0_s2_ff, sel0_s3_ff, sel0_filt_ff;
  always_ff @(posedge mclk) begin
    if (reset) begin
      sel0_s1_ff   <= 1'b0;
      sel0_s2_ff   <= 1'b0;
      sel0_s3_ff   <= 1'b0;
      sel0_filt_ff <= 1'b0;
    end else begin
      sel0_s1_ff <= clock_select_bits_in[0];
      sel0_s2_ff <= sel0_s1_ff;
      sel0_s3_ff <= sel0_s2_ff;
      if (sel0_s2_ff == sel0_s3_ff) sel0_filt_ff <= sel0_s3_ff;
    end
  end

  assign ten_s    = filt_ff[4];
  assign ten_fall = ten_prev_ff & ~ten_s;
  assign xtal     = (primary_osc_config == `PCRS_PCFG_LP) ||
                    (primary_osc_config == `PCRS_PCFG_XT) ||
                    (primary_osc_config == `PCRS_PCFG_HS);

  // -------------------------------------------------------------------
  // clock select bits
  // -------------------------------------------------------------------
  // enable drop clears bit 0
  always_ff @(posedge mclk) begin
    if (reset) begin
      sel_ff      <= `PCRS_SEL_RESET;
      ten_prev_ff <= 1'b0;
    end else begin
      ten_prev_ff <= ten_s;
      // software cannot keep bit 0 set while the timer oscillator is off
      sel_ff <= {filt_ff[3], sel0_filt_ff & ten_s};
      if (ten_fall && cur_src_ff == SRC_TIMER_XTAL) sel_ff[0] <= 1'b0;
    end
  end

  always_comb begin
    want_src = SRC_SLOW_INT;
    if (sel_ff == `PCRS_SEL_PRIMARY) want_src = SRC_PRIMARY;
    else if (sel_ff == `PCRS_SEL_TIMER) want_src = SRC_TIMER_XTAL;
    else if (primary_osc_config == `PCRS_PCFG_INT ||
             primary_osc_config == `PCRS_PCFG_INT_IO) want_src = SRC_PRIMARY;
  end

  // -------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------
  // cpu timer only after sleep, always for non-crystal
  assign cpu_done = (xtal && !asleep_ff) || (cpu_cnt_ff == 10'(`PCRS_CPU_CYCLES));
  assign ost_done    = !xtal || (ost_cnt_ff == `PCRS_OST_CYCLES);
  assign sync_done   = (state_ff == ST_SYNC) && (edge_cnt_ff == `PCRS_SYNC_EDGES);
  assign switch_done = sync_done || (state_ff == ST_EXTRA && cur_src_ff == SRC_PRIMARY);

  // sleep status is caught by a clocked sample during reset
  always_ff @(posedge mclk) begin
    if (reset) asleep_ff <= woke_from_sleep;
  end

  // one sequence for every reset source
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff   <= ST_BOOT;
      // dual-speed start on the slow oscillator
      cur_src_ff <= (dual_speed_enable && xtal) ? SRC_SLOW_INT : SRC_PRIMARY;
      tgt_src_ff <= SRC_PRIMARY;
    end else begin
      case (state_ff)
        ST_BOOT: if (cpu_done && ost_done) state_ff <= ST_EXTRA;
        ST_EXTRA: state_ff <= (cur_src_ff == SRC_PRIMARY) ? ST_RUN : ST_SYNC;
        ST_RUN: if (want_src != cur_src_ff) begin
          tgt_src_ff <= want_src;
          state_ff   <= (want_src == SRC_PRIMARY && xtal) ? ST_OST : ST_SYNC;
        end
        ST_OST: if (ost_cnt_ff == `PCRS_OST_CYCLES) state_ff <= ST_SYNC;
        ST_SYNC: if (sync_done) begin
          cur_src_ff <= tgt_src_ff;
          state_ff   <= ST_RUN;
        end
        default: state_ff <= ST_BOOT;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // counters
  // -------------------------------------------------------------------
  // crystal start-up counted on primary edges
  always_ff @(posedge mclk) begin
    if (reset || !(state_ff == ST_BOOT || state_ff == ST_OST)) ost_cnt_ff <= 11'h000;
    else if (fall[0] && ost_cnt_ff != `PCRS_OST_CYCLES) ost_cnt_ff <= ost_cnt_ff + 11'h001;
  end

  always_ff @(posedge mclk) begin
    if (reset) cpu_cnt_ff <= 10'h000;
    else if (state_ff == ST_BOOT && !cpu_done) cpu_cnt_ff <= cpu_cnt_ff + 10'h001;
  end

  // eight falling edges of the new source
  always_ff @(posedge mclk) begin
    if (reset || state_ff != ST_SYNC) edge_cnt_ff <= 4'h0;
    else if (fall[tgt_src_ff] && !sync_done) edge_cnt_ff <= edge_cnt_ff + 4'h1;
  end

  // -------------------------------------------------------------------
  // status flags
  // -------------------------------------------------------------------
  // flags set on the completed switch; stable flag drops in the start-up wait or a sync off primary
  always_ff @(posedge mclk) begin
    if (reset) begin
      ps_ff <= 1'b0;
      sa_ff <= 1'b0;
    end else if (switch_done) begin
      // stable only on primary, flag values
      ps_ff <= (state_ff == ST_SYNC) ? (tgt_src_ff == SRC_PRIMARY) : 1'b1;
      sa_ff <= (state_ff == ST_SYNC) && (tgt_src_ff == SRC_TIMER_XTAL);
    end else if (state_ff == ST_OST || (state_ff == ST_SYNC && tgt_src_ff != SRC_PRIMARY)) begin
      ps_ff <= 1'b0;
    end
  end

  // internal frequency settles after a long wait
  always_ff @(posedge mclk) begin
    if (reset || switch_done || internal_freq_select != ifs_seen_ff ||
        cur_src_ff != SRC_SLOW_INT || internal_freq_select == `PCRS_IFS_SLOWEST) begin
      internal_freq_stable_flag_cnt_ff <= 19'h00000;
      internal_freq_stable_flag_ff     <= 1'b0;
    end else if (internal_freq_stable_flag_cnt_ff == 19'(INTERNAL_FREQ_STABLE_FLAG_WAIT)) begin
      internal_freq_stable_flag_ff <= 1'b1;
    end else begin
      internal_freq_stable_flag_cnt_ff <= internal_freq_stable_flag_cnt_ff + 19'h00001;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) ifs_seen_ff <= `PCRS_IFS_SLOWEST;
    else ifs_seen_ff <= internal_freq_select;
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign clock_select_bits           = sel_ff;
  assign sys_clk_src                 = cur_src_ff;
  assign primary_stable_flag         = ps_ff;
  assign secondary_clock_active_flag = sa_ff;
  assign internal_freq_stable_flag   = internal_freq_stable_flag_ff;

  // core hold only while sync, the extra cycle, or boot started on the primary source
  assign core_hold = (state_ff == ST_SYNC) || (state_ff == ST_EXTRA) ||
                     (state_ff == ST_BOOT && cur_src_ff == SRC_PRIMARY);

  assign primary_osc_run = (cur_src_ff == SRC_PRIMARY) || state_ff == ST_BOOT ||
                           state_ff == ST_OST || (state_ff == ST_SYNC && tgt_src_ff == SRC_PRIMARY);
  // slow oscillator stops unless still needed
  assign slow_internal_osc_run = (cur_src_ff == SRC_SLOW_INT) || watchdog_uses_slow ||
                                 monitor_uses_slow || (primary_osc_config >= `PCRS_PCFG_INT) ||
                                 (state_ff == ST_SYNC && tgt_src_ff == SRC_SLOW_INT);
  // timer oscillator kept while enabled or in use
  assign timer_crystal_osc_run = ten_s || (cur_src_ff == SRC_TIMER_XTAL) ||
                                 (state_ff == ST_SYNC && tgt_src_ff == SRC_TIMER_XTAL);

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  AST_SEL_ZERO_AFTER_RESET: assert property ($fell(reset) |-> sel_ff == `PCRS_SEL_RESET)
    else $error("select not cleared by reset");
  AST_NO_OST_NONXTAL: assert property (!xtal |-> state_ff != ST_OST)
    else $error("start-up wait entered for non-crystal primary");
  AST_OST_FULL: assert property ($rose(state_ff == ST_SYNC) &&
                                 $past(state_ff) == ST_OST
                                 |-> $past(ost_cnt_ff) == `PCRS_OST_CYCLES)
    else $error("start-up count ended early");
  AST_HOLD_IN_SYNC: assert property ($past(state_ff) == ST_SYNC &&
                                     !$stable(cur_src_ff) |->
                                     $past(edge_cnt_ff) == `PCRS_SYNC_EDGES && $past(core_hold))
    else $error("source released before eight held edges");
  AST_RUN_DURING_OST: assert property (state_ff == ST_OST |-> !core_hold)
    else $error("core stalled during start-up count");
  AST_FLAGS_ON_PRIMARY: assert property (sync_done && tgt_src_ff == SRC_PRIMARY
                                         |=> ps_ff && !sa_ff)
    else $error("flags wrong after return to primary");
  AST_PS_MEANS_PRIMARY: assert property (ps_ff |-> cur_src_ff == SRC_PRIMARY)
    else $error("stable flag set off primary");
  AST_MUX_ONLY_HELD: assert property (!$stable(cur_src_ff) |-> $past(core_hold))
    else $error("source changed without hold");
  AST_EXTRA_CYCLE: assert property (state_ff == ST_EXTRA |=> state_ff != ST_EXTRA)
    else $error("extra cycle not single");
  AST_TIMER_FLAG: assert property (sync_done && tgt_src_ff == SRC_TIMER_XTAL
                                   |=> sa_ff && !ps_ff)
    else $error("timer switch flags wrong");
  AST_SEL0_DROP: assert property (ten_fall && cur_src_ff == SRC_TIMER_XTAL |=> !sel_ff[0])
    else $error("select bit 0 kept after enable drop");

  COV_RETURN_XTAL: cover property (state_ff == ST_OST ##1 state_ff == ST_SYNC);
  COV_TO_TIMER: cover property (sync_done && tgt_src_ff == SRC_TIMER_XTAL);
  COV_TO_SLOW: cover property (sync_done && tgt_src_ff == SRC_SLOW_INT);
  COV_INTERNAL_FREQ_STABLE_FLAG: cover property ($rose(internal_freq_stable_flag_ff));

endmodule : pcrs_switch

// ---- bench/pcrs_osc_model.sv ----
/*
  Oscillator sources beside the clock return switch: primary, slow internal
  and timer crystal. Each toggles only while its run enable is high.
  Assumes the switch drives the three run enables as plain levels.
*/
module pcrs_osc_model #(
  parameter int PRI_HALF_NS  = 20,
  parameter int SLOW_HALF_NS = 80,
  parameter int TMR_HALF_NS  = 100
) (
  input  wire logic primary_osc_run,
  input  wire logic slow_internal_osc_run,
  input  wire logic timer_crystal_osc_run,
  output logic      primary_osc_clk,
  output logic      slow_internal_osc_clk,
  output logic      timer_crystal_osc_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------------------------
  // free-running sources, stopped low when disabled
  // -------------------------------------------------------------------
  // a stopped source gives no edges, so a switch that forgets to enable it hangs
  initial begin
    primary_osc_clk       = 1'b0;
    slow_internal_osc_clk = 1'b0;
    timer_crystal_osc_clk = 1'b0;
  end
  always begin
    #(PRI_HALF_NS);
    primary_osc_clk = primary_osc_run ? ~primary_osc_clk : 1'b0;
  end
  always begin
    #(SLOW_HALF_NS);
    slow_internal_osc_clk = slow_internal_osc_run ? ~slow_internal_osc_clk : 1'b0;
  end
  always begin
    #(TMR_HALF_NS);
    timer_crystal_osc_clk = timer_crystal_osc_run ? ~timer_crystal_osc_clk : 1'b0;
  end
endmodule : pcrs_osc_model

// ---- bench/testbench.sv ----
/*
  Self-checking bench for the primary clock return switch.
  Assumes pcrs_pkg, pcrs_consts.svh and the oscillator model are compiled first.
*/
`include "pcrs_consts.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module testbench import pcrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {pcrs_src_t src; logic ps; logic sa;} pcrs_exp_t;
  logic       mclk, reset, pclk, sclk, tclk, t_en, dual, woke, wd_slow, mon_slow, mon_on;
  logic [1:0] sel_in, sel_out;
  logic [2:0] pcfg, ifs;
  logic       hold, ps, sa, ifsf, p_run, s_run, t_run;
  pcrs_src_t  src;
  pcrs_exp_t  exp_q[$];
  int         n_errors, total_checks, n;

  pcrs_switch #(.INTERNAL_FREQ_STABLE_FLAG_WAIT(50)) dut_u (
    .mclk(mclk), .reset(reset), .primary_osc_clk(pclk), .slow_internal_osc_clk(sclk),
    .timer_crystal_osc_clk(tclk), .clock_select_bits_in(sel_in), .timer_osc_enable(t_en),
    .primary_osc_config(pcfg), .internal_freq_select(ifs), .dual_speed_enable(dual),
    .woke_from_sleep(woke), .watchdog_uses_slow(wd_slow), .monitor_uses_slow(mon_slow),
    .clock_select_bits(sel_out), .sys_clk_src(src), .core_hold(hold),
    .primary_stable_flag(ps), .secondary_clock_active_flag(sa),
    .internal_freq_stable_flag(ifsf), .primary_osc_run(p_run),
    .slow_internal_osc_run(s_run), .timer_crystal_osc_run(t_run));
  pcrs_osc_model osc_u (
    .primary_osc_run(p_run), .slow_internal_osc_run(s_run), .timer_crystal_osc_run(t_run),
    .primary_osc_clk(pclk), .slow_internal_osc_clk(sclk), .timer_crystal_osc_clk(tclk));

  // 100 MHz system clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // -------------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic drive(input logic [1:0] s, input logic en);
    @(negedge mclk);
    sel_in = s;
    t_en   = en;
  endtask : drive
  // bounded wait for a source; returns the cycles spent
  task automatic wait_src(input pcrs_src_t want, output int cnt);
    cnt = 0;
    while (src !== want && cnt < 12000) begin
      @(negedge mclk);
      cnt++;
    end
    if (cnt >= 12000) begin
      n_errors++;
      $display("BAD wait_src expected %0h seen %0h", want, src);
      give_verdict();
    end
  endtask : wait_src
  // bounded wait for the core to leave its start-up hold; returns the cycles spent
  task automatic wait_run(output int cnt);
    cnt = 0;
    while (hold !== 1'b0 && cnt < 12000) begin
      @(negedge mclk);
      cnt++;
    end
    if (cnt >= 12000) begin
      n_errors++;
      $display("BAD core_hold expected 0 seen %0h", hold);
      give_verdict();
    end
  endtask : wait_run
  task automatic go(input pcrs_src_t s, input logic p, input logic a, input logic [1:0] sl,
                    input logic en);
    exp_q.push_back('{s, p, a});
    drive(sl, en);
    wait_src(s, n);
    repeat (3) @(negedge mclk);
  endtask : go

  // -------------------------------------------------------------------
  // watcher: each source change takes the oldest note off the queue
  // -------------------------------------------------------------------
  // flags land on the same edge as the source; compare a cycle later all the same
  initial begin : watch
    pcrs_src_t prev;
    pcrs_exp_t e;
    wait (mon_on === 1'b1);
    prev = src;
    forever begin
      @(negedge mclk);
      if (src !== prev) begin
        prev = src;
        @(negedge mclk);
        if (exp_q.size() == 0) begin
          n_errors++;
          $display("BAD sys_clk_src expected none seen %0h", src);
        end else begin
          e = exp_q.pop_front();
          `CHK("sys_clk_src", e.src, src)
          `CHK("primary_stable_flag", e.ps, ps)
          `CHK("secondary_clock_active_flag", e.sa, sa)
        end
      end
    end
  end

  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial begin
    {reset, sel_in, t_en, dual, woke, wd_slow, mon_slow, mon_on} = 9'h100;
    pcfg = `PCRS_PCFG_XT;
    ifs  = `PCRS_IFS_SLOWEST;
    void'($urandom(5325));
    repeat (20) @(negedge mclk);
    reset = 1'b0;
    wait_run(n);
    `CHK("boot_long", 1'b1, n > 4000)
    `CHK("sys_clk_src", SRC_PRIMARY, src)
    `CHK("primary_stable_flag", 1'b1, ps)
    `CHK("clock_select_bits", `PCRS_SEL_RESET, sel_out)
    mon_on = 1'b1;
    $display("test boot done");
    go(SRC_TIMER_XTAL, 1'b0, 1'b1, `PCRS_SEL_TIMER, 1'b1);
    exp_q.push_back('{SRC_PRIMARY, 1'b1, 1'b0});
    drive(`PCRS_SEL_PRIMARY, 1'b1);
    repeat (100) @(negedge mclk);
    `CHK("core_hold", 1'b0, hold)
    `CHK("sys_clk_src", SRC_TIMER_XTAL, src)
    wait_src(SRC_PRIMARY, n);
    `CHK("crystal_wait", 1'b1, n > 3900)
    repeat (3) @(negedge mclk);
    `CHK("timer_crystal_osc_run", 1'b1, t_run)
    $display("test crystal return done");
    ifs = 3'h1 + 3'($urandom % 7);
    go(SRC_SLOW_INT, 1'b0, 1'b0, 2'h2, 1'b0);
    repeat (70) @(negedge mclk);
    `CHK("internal_freq_stable_flag", 1'b1, ifsf)
    pcfg = `PCRS_PCFG_EXT;
    go(SRC_PRIMARY, 1'b1, 1'b0, `PCRS_SEL_PRIMARY, 1'b0);
    `CHK("skip_wait", 1'b1, n < 400)
    `CHK("slow_internal_osc_run", 1'b0, s_run)
    $display("test external return done");
    pcfg = `PCRS_PCFG_XT;
    go(SRC_TIMER_XTAL, 1'b0, 1'b1, `PCRS_SEL_TIMER, 1'b1);
    go(SRC_PRIMARY, 1'b1, 1'b0, `PCRS_SEL_TIMER, 1'b0);
    `CHK("clock_select_bits", 2'h0, sel_out)
    `CHK("timer_crystal_osc_run", 1'b0, t_run)
    $display("test enable drop done");
    pcfg = `PCRS_PCFG_INT;
    drive(2'h2, 1'b0);
    repeat (200) @(negedge mclk);
    `CHK("sys_clk_src", SRC_PRIMARY, src)
    drive(`PCRS_SEL_PRIMARY, 1'b0);
    // the select needs a few cycles through its synchroniser; keep the internal
    // primary until it reads 00, or a switch to the slow oscillator would start
    repeat (10) @(negedge mclk);
    pcfg = `PCRS_PCFG_XT;
    $display("test no switch done");
    go(SRC_TIMER_XTAL, 1'b0, 1'b1, `PCRS_SEL_TIMER, 1'b1);
    dual = 1'b1;
    exp_q.push_back('{SRC_SLOW_INT, 1'b0, 1'b0});
    exp_q.push_back('{SRC_PRIMARY, 1'b1, 1'b0});
    @(negedge mclk);
    {reset, sel_in, t_en} = 4'h8;
    repeat (20) @(negedge mclk);
    `CHK("sys_clk_src", SRC_SLOW_INT, src)
    `CHK("core_hold", 1'b0, hold)
    `CHK("clock_select_bits", `PCRS_SEL_RESET, sel_out)
    reset = 1'b0;
    wait_src(SRC_PRIMARY, n);
    repeat (5) @(negedge mclk);
    `CHK("notes_left", 0, exp_q.size())
    $display("test dual speed reset done");
    // non-crystal reset after sleep: only the short cpu delay holds the core
    {reset, dual, woke, wd_slow} = 4'hB;
    pcfg = `PCRS_PCFG_EXT;
    repeat (20) @(negedge mclk);
    reset = 1'b0;
    wait_run(n);
    `CHK("short_delay", 1'b1, n >= `PCRS_CPU_CYCLES && n < `PCRS_CPU_CYCLES + 20)
    `CHK("primary_stable_flag", 1'b1, ps)
    `CHK("slow_internal_osc_run", 1'b1, s_run)
    $display("test short delay reset done");
    give_verdict();
  end
endmodule : testbench
